// >>> logic/tcd_top.sv
// Thermometer command decoder: commands, registers, conversion control
//
// Overview of operation
// - Config command writes next byte into config, or reads it back.
// - Commands A8h/A9h return remaining count and slope; reads only.
// - Read-temperature returns two bytes of the latest completed result.
// - Start command begins a conversion; no data bytes follow it.
// - One-shot mode: one conversion per start, then idle.
// - Continuous mode: conversions repeat back to back until halted.
// - Stop command lets the running conversion finish, then stays idle.
// - Nonvolatile limit or config write finishes within 10 ms.
// - High-limit command reads or writes the high limit by direction.
// - Low-limit command reads or writes the low limit by direction.
// - Config value 02h gives active-high output and continuous mode.
// - Commands chain via repeated start; address, command, data acked.
// - Only address with the type code and select pins is answered.
// - One-shot: thermostat output holds result of last conversion.
`timescale 1ns/100ps
module tcd_top #(
  parameter int unsigned NV_CYCLES = tcd_pkg::NV_WRITE_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  input  wire logic [2:0]            sel_i,
  input  wire tcd_pkg::tcd_conv_res_t conv_res,
  output logic                       conv_start,
  output logic                       tout,
  output logic                       nv_busy,
  output logic [15:0]                high_limit_o,
  output logic [15:0]                low_limit_o
);

  function automatic logic tcd_known_cmd(input logic [7:0] c);
    tcd_known_cmd = c == tcd_pkg::CMD_READ_TEMP
                 || c == tcd_pkg::CMD_HIGH_LIMIT
                 || c == tcd_pkg::CMD_LOW_LIMIT
                 || c == tcd_pkg::CMD_CONFIG
                 || c == tcd_pkg::CMD_COUNT_REMAIN
                 || c == tcd_pkg::CMD_COUNT_SLOPE
                 || c == tcd_pkg::CMD_START_CONV
                 || c == tcd_pkg::CMD_STOP_CONV;
  endfunction : tcd_known_cmd

  tcd_pkg::tcd_bus_evt_t    evt;
  tcd_pkg::tcd_phase_t      phase_q;
  tcd_pkg::tcd_conv_state_t conv_q;
  logic [7:0]               cmd_q;
  logic [1:0]               idx_q;
  logic [7:0]               tx_data_q;
  logic [7:0]               wr_msb_q;
  logic                     one_shot_q;
  logic                     pol_q;
  logic [15:0]              high_limit_q;
  logic [15:0]              low_limit_q;
  logic [15:0]              temp_q;
  logic [7:0]               remain_q;
  logic [7:0]               slope_q;
  logic                     above_q;
  logic                     below_q;
  logic                     thermo_q;
  logic                     done_q;
  logic                     stop_q;
  logic                     conv_start_q;
  logic                     tout_q;
  logic [31:0]              nv_cnt_q;
  logic                     nv_busy_q;
  logic [7:0]               cfg_rd;

  tcd_i2c_slave u_slave (
    .ref_clk (ref_clk),
    .rst     (rst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sel_i   (sel_i),
    .tx_data (tx_data_q),
    .sda_o   (sda_o),
    .sda_oe  (sda_oe),
    .evt     (evt)
  );

  // Command and data byte decode
  wire       cmd_byte  = evt.rx_valid && phase_q == tcd_pkg::PH_CMD;
  wire       data_byte = evt.rx_valid && phase_q == tcd_pkg::PH_WDATA;
  wire [7:0] cmd_in    = tcd_known_cmd(evt.rx_data) ? evt.rx_data
                                                    : tcd_pkg::CMD_NONE;
  wire       start_cmd = cmd_byte && evt.rx_data == tcd_pkg::CMD_START_CONV;
  wire       stop_cmd  = cmd_byte && evt.rx_data == tcd_pkg::CMD_STOP_CONV;
  wire       cfg_wr    = data_byte && cmd_q == tcd_pkg::CMD_CONFIG
                         && idx_q == 2'h0;
  wire       high_wr   = data_byte && cmd_q == tcd_pkg::CMD_HIGH_LIMIT
                         && idx_q == 2'h1;
  wire       low_wr    = data_byte && cmd_q == tcd_pkg::CMD_LOW_LIMIT
                         && idx_q == 2'h1;
  wire       nv_start  = cfg_wr | high_wr | low_wr;
  wire       conv_done = conv_res.done;
  wire       halt      = (stop_q | stop_cmd) & ~start_cmd;

  always_comb begin
    cfg_rd                           = 8'h00;
    cfg_rd[tcd_pkg::CFG_DONE_BIT]    = done_q;
    cfg_rd[tcd_pkg::CFG_HIGH_BIT]    = above_q;
    cfg_rd[tcd_pkg::CFG_LOW_BIT]     = below_q;
    cfg_rd[tcd_pkg::CFG_NVBUSY_BIT]  = nv_busy_q;
    cfg_rd[tcd_pkg::CFG_POL_BIT]     = pol_q;
    cfg_rd[tcd_pkg::CFG_ONESHOT_BIT] = one_shot_q;
  end

  // Single-byte answers sit in the upper half of the word
  wire [15:0] rd_word =
      cmd_q == tcd_pkg::CMD_READ_TEMP    ? temp_q :
      cmd_q == tcd_pkg::CMD_HIGH_LIMIT   ? high_limit_q :
      cmd_q == tcd_pkg::CMD_LOW_LIMIT    ? low_limit_q :
      cmd_q == tcd_pkg::CMD_CONFIG       ? {cfg_rd, tcd_pkg::IDLE_BYTE} :
      cmd_q == tcd_pkg::CMD_COUNT_REMAIN ? {remain_q, tcd_pkg::IDLE_BYTE} :
      cmd_q == tcd_pkg::CMD_COUNT_SLOPE  ? {slope_q, tcd_pkg::IDLE_BYTE} :
      {tcd_pkg::IDLE_BYTE, tcd_pkg::IDLE_BYTE};
  wire [7:0] rd_byte = idx_q == 2'h0 ? rd_word[15:8] :
                       idx_q == 2'h1 ? rd_word[7:0]  : tcd_pkg::IDLE_BYTE;
  wire [1:0] idx_inc = idx_q == 2'h2 ? idx_q : idx_q + 2'h1;

  // Transaction phase; command survives repeated start for reads
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_q   <= tcd_pkg::PH_IDLE;
      cmd_q     <= tcd_pkg::CMD_NONE;
      idx_q     <= 2'h0;
      tx_data_q <= tcd_pkg::IDLE_BYTE;
      wr_msb_q  <= 8'h00;
    end else begin
      tx_data_q <= rd_byte;
      if (evt.start || evt.stop) begin
        phase_q <= tcd_pkg::PH_IDLE;
      end else if (evt.addr_ok) begin
        phase_q <= evt.rw ? tcd_pkg::PH_RDATA : tcd_pkg::PH_CMD;
        idx_q   <= 2'h0;
      end else if (cmd_byte) begin
        cmd_q   <= cmd_in;
        phase_q <= tcd_pkg::PH_WDATA;
        idx_q   <= 2'h0;
      end else if (data_byte) begin
        idx_q <= idx_inc;
        if (idx_q == 2'h0) begin
          wr_msb_q <= evt.rx_data;
        end
      end else if (evt.tx_load && phase_q == tcd_pkg::PH_RDATA) begin
        idx_q <= idx_inc;
      end
    end
  end

  // Thermostat settings; writes to read-only commands are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      one_shot_q   <= tcd_pkg::CFG_RST[tcd_pkg::CFG_ONESHOT_BIT];
      pol_q        <= tcd_pkg::CFG_RST[tcd_pkg::CFG_POL_BIT];
      high_limit_q <= tcd_pkg::HIGH_LIMIT_RST;
      low_limit_q  <= tcd_pkg::LOW_LIMIT_RST;
    end else begin
      if (cfg_wr) begin
        one_shot_q <= evt.rx_data[tcd_pkg::CFG_ONESHOT_BIT];
        pol_q      <= evt.rx_data[tcd_pkg::CFG_POL_BIT];
      end
      if (high_wr) begin
        high_limit_q <= {wr_msb_q, evt.rx_data};
      end
      if (low_wr) begin
        low_limit_q <= {wr_msb_q, evt.rx_data};
      end
    end
  end

  // Nonvolatile busy window; a write during it restarts the window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nv_cnt_q  <= 32'h0000_0000;
      nv_busy_q <= 1'b0;
    end else begin
      if (nv_start) begin
        nv_cnt_q <= 32'(NV_CYCLES);
      end else if (nv_cnt_q != 32'h0000_0000) begin
        nv_cnt_q <= nv_cnt_q - 32'h0000_0001;
      end
      nv_busy_q <= nv_start || nv_cnt_q > 32'h0000_0001;
    end
  end

  // Conversion sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_q       <= tcd_pkg::CV_IDLE;
      stop_q       <= 1'b0;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      unique case (conv_q)
        tcd_pkg::CV_IDLE: begin
          if (start_cmd) begin
            conv_q       <= tcd_pkg::CV_RUN;
            conv_start_q <= 1'b1;
            stop_q       <= 1'b0;
          end
        end
        tcd_pkg::CV_RUN: begin
          // Stop only takes effect at the end of the running conversion
          if (conv_done && (one_shot_q || halt)) begin
            conv_q <= tcd_pkg::CV_IDLE;
            stop_q <= 1'b0;
          end else if (conv_done) begin
            conv_start_q <= 1'b1;
            stop_q       <= halt;
          end else begin
            stop_q <= halt;
          end
        end
      endcase
    end
  end

  // Result capture; thermostat level changes only on a finished conversion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      temp_q   <= tcd_pkg::TEMP_RST;
      remain_q <= 8'h00;
      slope_q  <= 8'h00;
      above_q  <= 1'b0;
      below_q  <= 1'b0;
      thermo_q <= 1'b0;
      done_q   <= 1'b0;
      tout_q   <= 1'b0;
    end else begin
      if (conv_done && conv_q == tcd_pkg::CV_RUN) begin
        temp_q   <= conv_res.temp;
        remain_q <= conv_res.count_remain;
        slope_q  <= conv_res.count_slope;
        above_q  <= conv_res.above_high;
        below_q  <= conv_res.below_low;
        thermo_q <= conv_res.thermo;
        done_q   <= 1'b1;
      end else if (start_cmd && conv_q == tcd_pkg::CV_IDLE) begin
        done_q <= 1'b0;
      end
      tout_q <= pol_q ? thermo_q : ~thermo_q;
    end
  end

  assign conv_start   = conv_start_q;
  assign tout         = tout_q;
  assign nv_busy      = nv_busy_q;
  assign high_limit_o = high_limit_q;
  assign low_limit_o  = low_limit_q;

endmodule : tcd_top

// >>> logic/tcd_pkg.sv
// Constants and types of the thermometer command decoder
package tcd_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ_TEMP    = 8'hAA;
  localparam logic [7:0] CMD_HIGH_LIMIT   = 8'hA1;
  localparam logic [7:0] CMD_LOW_LIMIT    = 8'hA2;
  localparam logic [7:0] CMD_CONFIG       = 8'hAC;
  localparam logic [7:0] CMD_COUNT_REMAIN = 8'hA8;
  localparam logic [7:0] CMD_COUNT_SLOPE  = 8'hA9;
  localparam logic [7:0] CMD_START_CONV   = 8'hEE;
  localparam logic [7:0] CMD_STOP_CONV    = 8'h22;
  localparam logic [7:0] CMD_NONE         = 8'h00;

  // Device-type code of the address byte; value is arbitrary
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

  // Configuration byte field positions
  localparam int unsigned CFG_DONE_BIT    = 7;
  localparam int unsigned CFG_HIGH_BIT    = 6;
  localparam int unsigned CFG_LOW_BIT     = 5;
  localparam int unsigned CFG_NVBUSY_BIT  = 4;
  localparam int unsigned CFG_POL_BIT     = 1;
  localparam int unsigned CFG_ONESHOT_BIT = 0;

  // Values after reset
  localparam logic [7:0]  CFG_RST        = 8'h00;
  localparam logic [15:0] HIGH_LIMIT_RST = 16'h0000;
  localparam logic [15:0] LOW_LIMIT_RST  = 16'h0000;
  localparam logic [15:0] TEMP_RST       = 16'h0000;
  localparam logic [7:0]  IDLE_BYTE      = 8'hFF;

  // Bits per byte on the wire
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // Nonvolatile write time, longest, rounded down
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned NV_WRITE_MS     = 10;
  localparam int unsigned NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic       addr_ok;
    logic       rw;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_load;
  } tcd_bus_evt_t;

  typedef struct packed {
    logic        done;
    logic [15:0] temp;
    logic [7:0]  count_remain;
    logic [7:0]  count_slope;
    logic        above_high;
    logic        below_low;
    logic        thermo;
  } tcd_conv_res_t;

  typedef enum logic [2:0] {
    SL_IDLE  = 3'b000,
    SL_RX    = 3'b001,
    SL_RXACK = 3'b010,
    SL_TX    = 3'b011,
    SL_TXACK = 3'b100
  } tcd_slave_state_t;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_CMD   = 2'b01,
    PH_WDATA = 2'b10,
    PH_RDATA = 2'b11
  } tcd_phase_t;

  typedef enum logic {
    CV_IDLE = 1'b0,
    CV_RUN  = 1'b1
  } tcd_conv_state_t;

endpackage : tcd_pkg

// >>> logic/tcd_i2c_slave.sv
// Two-wire slave byte engine: framing, address match, ack, shifting
`timescale 1ns/100ps
module tcd_i2c_slave (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  input  wire logic [2:0]           sel_i,
  input  wire logic [7:0]           tx_data,
  output logic                      sda_o,
  output logic                      sda_oe,
  output tcd_pkg::tcd_bus_evt_t     evt
);

  logic [1:0]                scl_sync_q;
  logic [1:0]                sda_sync_q;
  logic [2:0]                sel_meta_q;
  logic [2:0]                sel_q;
  logic                      scl_q;
  logic                      sda_q;
  tcd_pkg::tcd_slave_state_t state_q;
  logic [3:0]                bit_cnt_q;
  logic [7:0]                shift_q;
  logic                      first_q;
  logic                      ack_q;
  logic                      rw_q;
  logic                      oe_q;
  tcd_pkg::tcd_bus_evt_t     evt_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sel_meta_q <= 3'h0;
      sel_q      <= 3'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      sel_meta_q <= sel_i;
      sel_q      <= sel_meta_q;
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  wire       scl_s     = scl_sync_q[1];
  wire       sda_s     = sda_sync_q[1];
  wire       scl_rise  = scl_s & ~scl_q;
  wire       scl_fall  = ~scl_s & scl_q;
  wire       start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire       stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  wire [7:0] rx_byte   = {shift_q[6:0], sda_s};
  wire       addr_hit  = rx_byte[7:1] == {tcd_pkg::DEV_TYPE_CODE, sel_q};
  wire       byte_in   = scl_rise && bit_cnt_q == tcd_pkg::LAST_BIT;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q   <= tcd_pkg::SL_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      first_q   <= 1'b0;
      ack_q     <= 1'b0;
      rw_q      <= 1'b0;
      oe_q      <= 1'b0;
      evt_q     <= '0;
    end else begin
      evt_q <= '0;
      if (start_det) begin
        // Repeated start restarts address phase from any state
        state_q     <= tcd_pkg::SL_RX;
        bit_cnt_q   <= 4'h0;
        first_q     <= 1'b1;
        oe_q        <= 1'b0;
        evt_q.start <= 1'b1;
      end else if (stop_det) begin
        state_q    <= tcd_pkg::SL_IDLE;
        oe_q       <= 1'b0;
        evt_q.stop <= 1'b1;
      end else begin
        unique case (state_q)
          tcd_pkg::SL_IDLE: begin
          end
          tcd_pkg::SL_RX: begin
            if (scl_rise) begin
              shift_q   <= rx_byte;
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (byte_in && first_q) begin
              ack_q         <= addr_hit;
              rw_q          <= rx_byte[0];
              evt_q.addr_ok <= addr_hit;
              evt_q.rw      <= rx_byte[0];
            end else if (byte_in) begin
              ack_q          <= 1'b1;
              evt_q.rx_valid <= 1'b1;
              evt_q.rx_data  <= rx_byte;
            end
            if (scl_fall && bit_cnt_q == tcd_pkg::BYTE_BITS) begin
              state_q <= tcd_pkg::SL_RXACK;
              oe_q    <= ack_q;
            end
          end
          tcd_pkg::SL_RXACK: begin
            if (scl_fall) begin
              oe_q      <= 1'b0;
              bit_cnt_q <= 4'h0;
              first_q   <= 1'b0;
              if (!ack_q) begin
                state_q <= tcd_pkg::SL_IDLE;
              end else if (first_q && rw_q) begin
                state_q       <= tcd_pkg::SL_TX;
                shift_q       <= tx_data;
                oe_q          <= ~tx_data[7];
                bit_cnt_q     <= 4'h1;
                evt_q.tx_load <= 1'b1;
              end else begin
                state_q <= tcd_pkg::SL_RX;
              end
            end
          end
          tcd_pkg::SL_TX: begin
            if (scl_fall && bit_cnt_q == tcd_pkg::BYTE_BITS) begin
              oe_q    <= 1'b0;
              state_q <= tcd_pkg::SL_TXACK;
            end else if (scl_fall) begin
              oe_q      <= ~shift_q[6];
              shift_q   <= {shift_q[6:0], 1'b1};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
          tcd_pkg::SL_TXACK: begin
            if (scl_rise) begin
              ack_q <= ~sda_s;
            end
            // Master not-ack ends the read; line left released
            if (scl_fall && ack_q) begin
              state_q       <= tcd_pkg::SL_TX;
              shift_q       <= tx_data;
              oe_q          <= ~tx_data[7];
              bit_cnt_q     <= 4'h1;
              evt_q.tx_load <= 1'b1;
            end else if (scl_fall) begin
              state_q <= tcd_pkg::SL_IDLE;
            end
          end
          default: begin
            state_q <= tcd_pkg::SL_IDLE;
            oe_q    <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = oe_q;
  assign evt    = evt_q;

endmodule : tcd_i2c_slave

// >>> tb/tcd_top_chk.sv
// Port-level assertions for the thermometer command decoder
`timescale 1ns/100ps
module tcd_top_chk #(
  parameter int unsigned NV_CYCLES = 20
) (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   scl_i,
  input wire logic                   sda_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe,
  input wire logic [2:0]             sel_i,
  input wire tcd_pkg::tcd_conv_res_t conv_res,
  input wire logic                   conv_start,
  input wire logic                   tout,
  input wire logic                   nv_busy,
  input wire logic [15:0]            high_limit_o,
  input wire logic [15:0]            low_limit_o
);
  logic [31:0] nv_cnt_q;
  logic [3:0]  done_sh_q;
  logic [3:0]  rst_sh_q;

  always_ff @(posedge ref_clk) begin
    nv_cnt_q  <= nv_busy ? nv_cnt_q + 32'h1 : 32'h0;
    done_sh_q <= {done_sh_q[2:0], conv_res.done};
    rst_sh_q  <= {rst_sh_q[2:0], rst};
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_oe_steady; scl_i && $past(scl_i) |-> $stable(sda_oe); endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("data drive moved while bus clock high");
  property p_pull_low; sda_oe |-> sda_o == 1'b0; endproperty
  a_pull_low: assert property (p_pull_low)
    else $error("driven data level not low");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("conversion start longer than one cycle");
  property p_nv_max; nv_cnt_q <= NV_CYCLES; endproperty
  a_nv_max: assert property (p_nv_max)
    else $error("nonvolatile write window too long");
  property p_nv_min; $rose(nv_busy) |-> nv_busy [*8]; endproperty
  a_nv_min: assert property (p_nv_min)
    else $error("nonvolatile write window too short");
  // Polarity writes also move the output, always inside the write window
  property p_tout_hold;
    $changed(tout) |-> (|done_sh_q) || nv_busy || (|rst_sh_q);
  endproperty
  a_tout_hold: assert property (p_tout_hold)
    else $error("thermostat output moved without a conversion");
  property p_high_nv; $changed(high_limit_o) |-> nv_busy; endproperty
  a_high_nv: assert property (p_high_nv)
    else $error("high limit moved without a write");
  property p_low_nv; $changed(low_limit_o) |-> nv_busy; endproperty
  a_low_nv: assert property (p_low_nv)
    else $error("low limit moved without a write");
endmodule : tcd_top_chk

bind tcd_top tcd_top_chk #(.NV_CYCLES(NV_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .sel_i(sel_i), .conv_res(conv_res),
  .conv_start(conv_start), .tout(tout), .nv_busy(nv_busy),
  .high_limit_o(high_limit_o), .low_limit_o(low_limit_o)
);

// >>> tb/tcd_bus_master.sv
// Two-wire bus master model for the decoder's bus pins
`timescale 1ns/100ps
module tcd_bus_master (
  input  wire logic       ref_clk,
  input  wire logic       sda_in,
  input  wire logic [2:0] addr_sel,
  output logic            scl_o,
  output logic            sda_low
);
  initial begin
    scl_o   = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hold

  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic seen);
    sda_low <= ~b;
    hold(6);
    scl_o <= 1'b1;
    hold(8);
    seen = sda_in;
    scl_o <= 1'b0;
    hold(2);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, input logic nack,
                         output logic [7:0] got, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], got[i]);
    bit_io(nack, s);
    ack = ~s;
  endtask : byte_io

  // Also a repeated start when no stop came first
  task automatic start_cond;
    sda_low <= 1'b0;
    hold(4);
    scl_o <= 1'b1;
    hold(6);
    sda_low <= 1'b1;
    hold(6);
    scl_o <= 1'b0;
    hold(2);
  endtask : start_cond

  task automatic stop_cond;
    sda_low <= 1'b1;
    hold(4);
    scl_o <= 1'b1;
    hold(6);
    sda_low <= 1'b0;
    hold(6);
  endtask : stop_cond

  task automatic wr(input logic [7:0] cmd, input int nd,
                    input logic [15:0] d, output logic [7:0] acks);
    logic [7:0] g;
    logic       a;
    start_cond;
    byte_io({tcd_pkg::DEV_TYPE_CODE, addr_sel, 1'b0}, 1'b1, g, a);
    acks = {7'h00, a};
    byte_io(cmd, 1'b1, g, a);
    acks = acks + {7'h00, a};
    for (int i = 0; i < nd; i++) begin
      byte_io(d[15 - 8 * i -: 8], 1'b1, g, a);
      acks = acks + {7'h00, a};
    end
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input int nb,
                    output logic [23:0] got, output logic [7:0] acks);
    logic [7:0] g;
    logic       a;
    wr(cmd, 0, 16'h0000, acks);
    start_cond;
    byte_io({tcd_pkg::DEV_TYPE_CODE, addr_sel, 1'b1}, 1'b1, g, a);
    acks = acks + {7'h00, a};
    got = 24'hFFFFFF;
    for (int i = 0; i < nb; i++) begin
      byte_io(8'hFF, i == nb - 1, g, a);
      got[23 - 8 * i -: 8] = g;
    end
    stop_cond;
  endtask : rd
endmodule : tcd_bus_master

// >>> tb/tb_thermometer_command_decoder.sv
// Self-checking bench for the thermometer command decoder
`timescale 1ns/100ps
module tb_thermometer_command_decoder;
  localparam int NV = 200;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic [2:0]             msel = 3'h2;
  logic [2:0]             dsel = 3'h2;
  tcd_pkg::tcd_conv_res_t res = '0;
  logic                   stray = 1'b0;
  logic [5:0]             cnt = 6'h00;
  int                     n_st = 0;
  int                     mismatches = 0;
  int                     checked = 0;
  wire                    sda_o, sda_oe, scl, m_low, cst, tout, nvb;
  wire [15:0]             hl, ll;
  wire                    sda = ~((sda_oe & ~sda_o) | m_low);

  always #12.5 ref_clk = ~ref_clk;

  tcd_top #(.NV_CYCLES(NV)) dut (
    .ref_clk(ref_clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .sel_i(dsel), .conv_res(res),
    .conv_start(cst), .tout(tout), .nv_busy(nvb),
    .high_limit_o(hl), .low_limit_o(ll)
  );
  tcd_bus_master m (
    .ref_clk(ref_clk), .sda_in(sda), .addr_sel(msel),
    .scl_o(scl), .sda_low(m_low)
  );

  // Conversion core stand-in: done 30 cycles after each start
  always @(posedge ref_clk) begin
    res.done <= (cnt == 6'h01) || stray;
    if (cst === 1'b1) cnt <= 6'h1E;
    else if (cnt != 6'h00) cnt <= cnt - 6'h01;
    if (rst) n_st <= 0;
    else if (cst === 1'b1) n_st <= n_st + 1;
  end

  task automatic cmp(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Writes are spaced by the whole nonvolatile window
  task automatic wait_nv;
    int k;
    for (k = 0; k < NV + 50 && nvb !== 1'b0; k++) @(posedge ref_clk);
    if (k >= NV + 50) begin
      mismatches++;
      $display("BAD nv_busy expected 0 seen 1");
      tally_and_finish;
    end
  endtask : wait_nv

  task automatic sc_addr;
    logic [7:0] a;
    msel <= 3'h5;
    m.wr(tcd_pkg::CMD_HIGH_LIMIT, 2, 16'h1234, a);
    m.stop_cond;
    cmp("miss acks", 24'h0, 24'(a));
    cmp("miss limit", 24'h0, 24'(hl));
    // Move the select pins to the master's value; the rest of the run uses 5
    dsel <= 3'h5;
    m.wr(8'h55, 2, 16'h1234, a);
    m.stop_cond;
    cmp("unknown acks", 24'h4, 24'(a));
    cmp("unknown limits", 24'h0, 24'(hl | ll));
    cmp("unknown starts", 24'h0, 24'(n_st));
    cmp("unknown nv", 24'h0, 24'(nvb));
  endtask : sc_addr

  task automatic sc_limits;
    logic [7:0]  a, b, c;
    logic [23:0] g;
    m.wr(tcd_pkg::CMD_CONFIG, 1, 16'h0200, a);
    cmp("nv busy", 24'h1, 24'(nvb));
    wait_nv;
    m.wr(tcd_pkg::CMD_HIGH_LIMIT, 2, 16'h2800, b);
    wait_nv;
    m.wr(tcd_pkg::CMD_LOW_LIMIT, 2, 16'h0A00, c);
    m.stop_cond;
    wait_nv;
    cmp("chain acks", 24'h0B, 24'(a + b + c));
    cmp("high limit", 24'h2800, 24'(hl));
    cmp("low limit", 24'h0A00, 24'(ll));
    m.rd(tcd_pkg::CMD_CONFIG, 1, g, a);
    cmp("config", 24'h02FFFF, g);
    m.rd(tcd_pkg::CMD_HIGH_LIMIT, 3, g, a);
    cmp("high read", 24'h2800FF, g);
    m.rd(tcd_pkg::CMD_LOW_LIMIT, 2, g, a);
    cmp("low read", 24'h0A00FF, g);
  endtask : sc_limits

  task automatic sc_cont;
    logic [7:0]  a;
    logic [23:0] g;
    int          n0;
    res.temp <= 16'h1980;
    res.count_remain <= 8'h0C;
    res.count_slope <= 8'h10;
    res.thermo <= 1'b1;
    res.above_high <= 1'b1;
    m.wr(tcd_pkg::CMD_START_CONV, 0, 16'h0000, a);
    m.stop_cond;
    n0 = n_st;
    m.hold(200);
    cmp("repeating", 24'h1, 24'(n_st - n0 > 4));
    m.wr(tcd_pkg::CMD_STOP_CONV, 0, 16'h0000, a);
    m.stop_cond;
    m.hold(100);
    n0 = n_st;
    m.hold(200);
    cmp("halted", 24'h0, 24'(n_st - n0));
    cmp("tout active high", 24'h1, 24'(tout));
    m.rd(tcd_pkg::CMD_READ_TEMP, 2, g, a);
    cmp("temp", 24'h1980FF, g);
    m.rd(tcd_pkg::CMD_COUNT_REMAIN, 1, g, a);
    cmp("remain", 24'h0CFFFF, g);
    m.rd(tcd_pkg::CMD_COUNT_SLOPE, 1, g, a);
    cmp("slope", 24'h10FFFF, g);
    m.rd(tcd_pkg::CMD_CONFIG, 1, g, a);
    cmp("config done", 24'hC2FFFF, g);
  endtask : sc_cont

  task automatic sc_oneshot;
    logic [7:0]  a;
    logic [23:0] g;
    int          n0;
    m.wr(tcd_pkg::CMD_CONFIG, 1, 16'h0100, a);
    m.stop_cond;
    wait_nv;
    res.thermo <= 1'b0;
    n0 = n_st;
    m.wr(tcd_pkg::CMD_START_CONV, 0, 16'h0000, a);
    m.stop_cond;
    m.hold(200);
    cmp("one shot", 24'h1, 24'(n_st - n0));
    cmp("tout low poll", 24'h1, 24'(tout));
    // Stray completion while idle must not reach the output
    res.thermo <= 1'b1;
    stray <= 1'b1;
    m.hold(1);
    stray <= 1'b0;
    m.hold(5);
    cmp("tout held", 24'h1, 24'(tout));
    res.temp <= 16'h1100;
    res.above_high <= 1'b0;
    res.below_low <= 1'b1;
    m.wr(tcd_pkg::CMD_START_CONV, 0, 16'h0000, a);
    m.stop_cond;
    m.hold(200);
    cmp("second shot", 24'h2, 24'(n_st - n0));
    cmp("tout new", 24'h0, 24'(tout));
    m.rd(tcd_pkg::CMD_READ_TEMP, 2, g, a);
    cmp("temp shot", 24'h1100FF, g);
    m.rd(tcd_pkg::CMD_CONFIG, 1, g, a);
    cmp("config shot", 24'hA1FFFF, g);
  endtask : sc_oneshot

  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    sc_addr;
    sc_limits;
    sc_cont;
    sc_oneshot;
    tally_and_finish;
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish;
  end
endmodule : tb_thermometer_command_decoder
